// ### inc/dc_defines.vh
// data cache constants: geometry, bus commands, fsm states
// assumes inclusion by every design file of the cache
`ifndef DC_DEFINES_VH
`define DC_DEFINES_VH
`define DC_SETS 128
`define DC_IDX_W 7
`define DC_WORDS 4
`define DC_OFS_W 2
`define DC_TAG_W 21
`define DC_TAG_LSB 11
`define DC_IDX_LSB 4
`define DC_WRD_LSB 2
`define DC_CMD_RD 2'h0
`define DC_CMD_WR 2'h1
`define DC_CMD_BRD 2'h2
`define DC_CMD_BWR 2'h3
`define DC_ST_IDLE 3'h0
`define DC_ST_WB 3'h1
`define DC_ST_FILL 3'h2
`define DC_ST_SINGLE 3'h3
`define DC_ST_DONE 3'h4
`endif

// ### hdl/dc_way.v
// one way of the data cache: tag, valid, dirty, lock and data arrays
// assumes a single clock and synchronous active-high reset from the cache top
`timescale 1ns/1ns
`include "dc_defines.vh"
module dc_way #(
    parameter SETS = `DC_SETS,
    parameter IDX_W = `DC_IDX_W,
    parameter TAG_W = `DC_TAG_W
) (
    input wire clk,
    input wire rst,
    input wire [IDX_W-1:0] idx,
    input wire [1:0] wsel,
    input wire [TAG_W-1:0] tag_in,
    input wire tag_we,
    input wire word_we,
    input wire [31:0] word_in,
    input wire [3:0] word_be,
    input wire dirty_set,
    input wire dirty_clr,
    input wire lock_we,
    input wire lock_in,
    input wire inval,
    output wire [TAG_W-1:0] tag_out,
    output wire valid_out,
    output wire dirty_out,
    output wire lock_out,
    output wire [31:0] word_out
);
    reg [TAG_W-1:0] tag_mem [0:SETS-1];
    reg [31:0] data_mem [0:SETS*4-1];
    reg [SETS-1:0] valid;
    reg [SETS-1:0] dirty;
    reg [SETS-1:0] lock;
    wire [IDX_W+1:0] waddr;
    integer b;
    assign waddr = {idx, wsel};
    assign tag_out = tag_mem[idx];
    assign valid_out = valid[idx];
    assign dirty_out = dirty[idx];
    assign lock_out = lock[idx];
    assign word_out = data_mem[waddr];
    // ======================================
    // state bits, tracked per block
    always @(posedge clk) begin
        if (rst) begin
            valid <= {SETS{1'b0}};
            dirty <= {SETS{1'b0}};
            lock <= {SETS{1'b0}};
        end else begin
            if (tag_we) begin
                valid[idx] <= 1'b1; // [R2]
            end
            if (inval) begin
                valid[idx] <= 1'b0;
            end
            if (dirty_clr) begin
                dirty[idx] <= 1'b0;
            end
            if (dirty_set) begin
                dirty[idx] <= 1'b1;
            end
            if (lock_we) begin
                lock[idx] <= lock_in; // [R4]
            end
        end
    end
    // ======================================
    // arrays have no reset, valid bits guard them
    always @(posedge clk) begin
        if (tag_we) begin
            tag_mem[idx] <= tag_in;
        end
        if (word_we) begin
            for (b = 0; b < 4; b = b + 1) begin
                if (word_be[b]) begin
                    data_mem[waddr][b*8 +: 8] <= word_in[b*8 +: 8];
                end
            end
        end
    end
endmodule // dc_way

// ### hdl/dc_cache.v
// two-way set-associative data cache between load/store unit and system bus
// assumes the mmu supplies page attributes with each request, bus on same clock
//
// How it works
// [R1] 4 Kbytes of storage as two ways of 128 sets, any address may sit in either way of its set.
// [R2] blocks are four 32-bit words and valid, dirty and lock state are kept per block.
// [R3] tags compare physical addresses and a miss with both ways valid replaces the least recently used way.
// [R4] a lock request from the core pins an individual block in the cache.
// [R5] a locked way is never a victim and a miss to a fully locked set is served uncached.
// [R6] hits answer one clock after the request and misses answer two clocks after the last fill beat; write-through stores answer after their single write.
// [R7] a cacheable miss fetches the full block as a four-beat burst into the chosen way.
// [R8] each access uses the copy-back or write-through attribute given for its page.
// [R9] cache-inhibited accesses go straight to the bus and never allocate.
// [R10] a dirty victim is burst back before the refill and write-through stores always go out.
`timescale 1ns/1ns
`include "dc_defines.vh"
module dc_cache #(
    parameter SETS = `DC_SETS,
    parameter IDX_W = `DC_IDX_W,
    parameter TAG_W = `DC_TAG_W
) (
    input wire clk,
    input wire rst,
    input wire req_valid,
    input wire req_write,
    input wire [31:0] req_addr,
    input wire [31:0] req_wdata,
    input wire [3:0] req_be,
    input wire req_inhibit,
    input wire req_wthru,
    input wire req_lock,
    input wire req_unlock,
    output wire req_ready,
    output reg resp_valid,
    output reg [31:0] resp_rdata,
    output reg bus_req,
    output reg [1:0] bus_cmd,
    output reg [31:0] bus_addr,
    output reg [31:0] bus_wdata,
    output reg [3:0] bus_be,
    input wire bus_ack,
    input wire [31:0] bus_rdata
);
    reg [2:0] state;
    reg [SETS-1:0] lru;
    reg [1:0] beat;
    reg vic;
    reg [31:0] hold_addr;
    reg [31:0] hold_wdata;
    reg [3:0] hold_be;
    reg hold_write;
    reg hold_wthru;
    reg hold_lock;
    reg [31:0] pend_data;
    wire [TAG_W-1:0] tag0, tag1;
    wire v0, v1, d0, d1, l0, l1;
    wire [31:0] w0, w1;
    wire [31:0] a;
    wire [IDX_W-1:0] idx;
    wire [TAG_W-1:0] tag;
    wire [1:0] wsel;
    wire idle;
    wire hit0, hit1, hit;
    wire vic_pick;
    wire all_locked;
    reg [1:0] next_beat;
    reg we0, we1, tw0, tw1, ds0, ds1, dc0, dc1, lw0, lw1;
    reg [31:0] win;
    reg [3:0] wbe;
    reg [1:0] wsel_m;

    assign idle = (state == `DC_ST_IDLE);
    assign a = idle ? req_addr : hold_addr;
    assign idx = a[`DC_TAG_LSB-1:`DC_IDX_LSB];
    assign tag = a[31:`DC_TAG_LSB];
    assign wsel = a[`DC_IDX_LSB-1:`DC_WRD_LSB];
    assign hit0 = v0 && (tag0 == tag); // [R3]
    assign hit1 = v1 && (tag1 == tag); // [R3]
    assign hit = hit0 | hit1;
    assign all_locked = l0 & l1;
    // invalid way first, then lru, never a locked way
    assign vic_pick = !v0 ? (l0 ? 1'b1 : 1'b0) :
                      !v1 ? (l1 ? 1'b0 : 1'b1) :
                      l0 ? 1'b1 : l1 ? 1'b0 : lru[idx]; // [R3] [R5]
    // a write-through store hit must still wait for memory, so it is not a fast hit
    assign req_ready = idle;

    // ======================================
    // array write controls
    always @* begin
        we0 = 1'b0;
        we1 = 1'b0;
        tw0 = 1'b0;
        tw1 = 1'b0;
        ds0 = 1'b0;
        ds1 = 1'b0;
        dc0 = 1'b0;
        dc1 = 1'b0;
        lw0 = 1'b0;
        lw1 = 1'b0;
        win = req_wdata;
        wbe = req_be;
        wsel_m = wsel;
        if (idle && req_valid && !req_inhibit && hit) begin
            if (req_write) begin
                we0 = hit0;
                we1 = hit1;
                ds0 = hit0 && !req_wthru; // [R8]
                ds1 = hit1 && !req_wthru; // [R8]
            end
            lw0 = hit0 && (req_lock || req_unlock); // [R4]
            lw1 = hit1 && (req_lock || req_unlock);
        end else if (state == `DC_ST_FILL && bus_ack) begin
            wsel_m = beat;
            win = bus_rdata;
            wbe = 4'hF;
            we0 = !vic;
            we1 = vic; // [R7]
            if (beat == 2'h3) begin
                tw0 = !vic;
                tw1 = vic;
                dc0 = !vic;
                dc1 = vic;
                lw0 = !vic && hold_lock;
                lw1 = vic && hold_lock;
            end
        end else if (state == `DC_ST_DONE && hold_write) begin
            // merge the store into the freshly filled block
            win = hold_wdata;
            wbe = hold_be;
            we0 = !vic;
            we1 = vic;
            ds0 = !vic && !hold_wthru; // [R8]
            ds1 = vic && !hold_wthru;
        end else if (state == `DC_ST_WB) begin
            // word of the next beat, loaded into bus_wdata at this ack
            wsel_m = next_beat;
        end else if (idle && !hit) begin
            wsel_m = 2'h0;
        end
    end

    dc_way #(.SETS(SETS), .IDX_W(IDX_W), .TAG_W(TAG_W)) u_way0 ( // [R1]
        .clk(clk), .rst(rst), .idx(idx), .wsel(wsel_m), .tag_in(tag), .tag_we(tw0),
        .word_we(we0), .word_in(win), .word_be(wbe), .dirty_set(ds0), .dirty_clr(dc0),
        .lock_we(lw0), .lock_in(idle ? req_lock : hold_lock), .inval(1'b0),
        .tag_out(tag0), .valid_out(v0), .dirty_out(d0), .lock_out(l0), .word_out(w0)
    );
    dc_way #(.SETS(SETS), .IDX_W(IDX_W), .TAG_W(TAG_W)) u_way1 ( // [R1]
        .clk(clk), .rst(rst), .idx(idx), .wsel(wsel_m), .tag_in(tag), .tag_we(tw1),
        .word_we(we1), .word_in(win), .word_be(wbe), .dirty_set(ds1), .dirty_clr(dc1),
        .lock_we(lw1), .lock_in(idle ? req_lock : hold_lock), .inval(1'b0),
        .tag_out(tag1), .valid_out(v1), .dirty_out(d1), .lock_out(l1), .word_out(w1)
    );

    always @* begin
        next_beat = beat + 2'h1;
    end

    // ======================================
    // control state machine
    always @(posedge clk) begin
        if (rst) begin
            state <= `DC_ST_IDLE;
            lru <= {SETS{1'b0}};
            beat <= 2'h0;
            vic <= 1'b0;
            hold_addr <= 32'h0000_0000;
            hold_wdata <= 32'h0000_0000;
            hold_be <= 4'h0;
            hold_write <= 1'b0;
            hold_wthru <= 1'b0;
            hold_lock <= 1'b0;
            pend_data <= 32'h0000_0000;
            resp_valid <= 1'b0;
            resp_rdata <= 32'h0000_0000;
            bus_req <= 1'b0;
            bus_cmd <= `DC_CMD_RD;
            bus_addr <= 32'h0000_0000;
            bus_wdata <= 32'h0000_0000;
            bus_be <= 4'h0;
        end else begin
            resp_valid <= 1'b0;
            case (state)
                `DC_ST_IDLE: begin
                    if (req_valid) begin
                        hold_addr <= req_addr;
                        hold_wdata <= req_wdata;
                        hold_be <= req_be;
                        hold_write <= req_write;
                        hold_wthru <= req_wthru;
                        hold_lock <= req_lock;
                        if (req_inhibit || (!hit && all_locked)) begin
                            // single beat straight to the bus, nothing allocated
                            state <= `DC_ST_SINGLE; // [R9] [R5]
                            bus_req <= 1'b1;
                            bus_cmd <= req_write ? `DC_CMD_WR : `DC_CMD_RD;
                            bus_addr <= req_addr;
                            bus_wdata <= req_wdata;
                            bus_be <= req_write ? req_be : 4'hF;
                        end else if (hit) begin
                            lru[idx] <= hit0; // [R3]
                            if (req_write && req_wthru) begin
                                state <= `DC_ST_SINGLE; // [R10] [R8]
                                bus_req <= 1'b1;
                                bus_cmd <= `DC_CMD_WR;
                                bus_addr <= req_addr;
                                bus_wdata <= req_wdata;
                                bus_be <= req_be;
                            end else begin
                                resp_valid <= 1'b1; // [R6]
                                resp_rdata <= hit0 ? w0 : w1;
                            end
                        end else begin
                            vic <= vic_pick;
                            beat <= 2'h0;
                            bus_req <= 1'b1;
                            if ((vic_pick ? (v1 && d1) : (v0 && d0))) begin
                                state <= `DC_ST_WB; // [R10]
                                bus_cmd <= `DC_CMD_BWR;
                                bus_addr <= {(vic_pick ? tag1 : tag0), idx, 4'h0};
                                bus_wdata <= vic_pick ? w1 : w0;
                                bus_be <= 4'hF;
                            end else begin
                                state <= `DC_ST_FILL; // [R7]
                                bus_cmd <= `DC_CMD_BRD;
                                bus_addr <= {tag, idx, 4'h0};
                                bus_be <= 4'hF;
                            end
                        end
                    end
                end
                `DC_ST_WB: begin
                    if (bus_ack) begin
                        beat <= next_beat;
                        bus_addr <= {bus_addr[31:`DC_IDX_LSB], next_beat, 2'h0};
                        bus_wdata <= vic ? w1 : w0;
                        if (beat == 2'h3) begin
                            state <= `DC_ST_FILL; // [R10]
                            beat <= 2'h0;
                            bus_cmd <= `DC_CMD_BRD;
                            bus_addr <= {hold_addr[31:`DC_IDX_LSB], 4'h0};
                        end
                    end
                end
                `DC_ST_FILL: begin
                    if (bus_ack) begin
                        beat <= next_beat;
                        bus_addr <= {bus_addr[31:`DC_IDX_LSB], next_beat, 2'h0};
                        if (beat == wsel) begin
                            pend_data <= bus_rdata;
                        end
                        if (beat == 2'h3) begin
                            state <= `DC_ST_DONE; // [R7]
                            bus_req <= 1'b0;
                            lru[idx] <= !vic;
                        end
                    end
                end
                `DC_ST_SINGLE: begin
                    if (bus_ack) begin
                        bus_req <= 1'b0;
                        resp_valid <= 1'b1; // [R6]
                        resp_rdata <= bus_rdata;
                        state <= `DC_ST_IDLE;
                    end
                end
                `DC_ST_DONE: begin
                    // two clocks after the last fill beat, as the miss penalty allows
                    resp_valid <= 1'b1; // [R6]
                    resp_rdata <= pend_data;
                    if (hold_write && hold_wthru) begin
                        state <= `DC_ST_SINGLE; // [R10]
                        resp_valid <= 1'b0;
                        bus_req <= 1'b1;
                        bus_cmd <= `DC_CMD_WR;
                        bus_addr <= hold_addr;
                        bus_wdata <= hold_wdata;
                        bus_be <= hold_be;
                    end else begin
                        state <= `DC_ST_IDLE;
                    end
                end
                default: begin
                    state <= `DC_ST_IDLE;
                    bus_req <= 1'b0;
                end
            endcase
        end
    end
endmodule // dc_cache

// ### verification/dc_cache_chk.sv
// assertion checker for the data cache core and bus ports
// assumes binding onto dc_cache, one clock, synchronous active-high reset
`timescale 1ns/1ns
module dc_cache_chk (
    input wire clk,
    input wire rst,
    input wire req_valid,
    input wire req_write,
    input wire req_inhibit,
    input wire req_wthru,
    input wire req_ready,
    input wire resp_valid,
    input wire bus_req,
    input wire [1:0] bus_cmd,
    input wire [31:0] bus_addr,
    input wire [31:0] bus_wdata,
    input wire bus_ack
);
    // ========================================
    // helpers
    wire take = req_valid && req_ready;
    wire beat = bus_req && bus_ack;
    wire last_beat = beat && (bus_addr[3:2] == 2'h3);
    // a write-through miss ends in a single write, not at the fill
    reg tk_wt;
    always @(posedge clk) begin
        if (rst) begin
            tk_wt <= 1'b0;
        end else if (take) begin
            tk_wt <= req_write && req_wthru;
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // ========================================
    // assertions
    busy_block_a: assert property (bus_req |-> !req_ready)
        else $error("request accepted during a bus transfer");
    beat_hold_a: assert property (bus_req && !bus_ack |=> bus_req && $stable(bus_addr)
        && $stable(bus_cmd) && $stable(bus_wdata)) else $error("bus beat changed before ack");
    burst_step_a: assert property (beat && bus_cmd[1] && !last_beat |=> bus_req
        && bus_cmd == $past(bus_cmd) && bus_addr == $past(bus_addr) + 32'h0000_0004)
        else $error("burst beat did not advance by one word");
    burst_align_a: assert property ($rose(bus_req) && bus_cmd[1] |-> bus_addr[3:0] == 4'h0)
        else $error("burst not started at word zero");
    wb_then_fill_a: assert property (last_beat && bus_cmd == 2'h3 |-> ##[1:2]
        (bus_req && bus_cmd == 2'h2 && bus_addr[3:0] == 4'h0)) else $error("no refill after write back");
    fill_resp_a: assert property (last_beat && bus_cmd == 2'h2 && !tk_wt |-> ##[1:2] resp_valid)
        else $error("miss answer late");
    single_resp_a: assert property (beat && !bus_cmd[1] |-> ##[1:2] resp_valid)
        else $error("single access answer late");
    quick_start_a: assert property (take && !req_inhibit && !(req_write && req_wthru)
        |=> resp_valid || bus_req) else $error("neither hit answer nor bus start");
    inh_single_a: assert property (take && req_inhibit |=> bus_req
        && bus_cmd == {1'b0, $past(req_write)}) else $error("inhibited access not single");
    wthru_out_a: assert property (take && req_write && req_wthru && !req_inhibit
        |-> ##[1:80] (beat && bus_cmd == 2'h1)) else $error("write-through store not written");
    resp_quiet_a: assert property (resp_valid |-> !bus_req)
        else $error("answer while bus busy");
    cover property (beat && bus_cmd == 2'h3);
    cover property (take && req_inhibit);
    cover property (take ##1 resp_valid);
endmodule // dc_cache_chk

bind dc_cache dc_cache_chk u_dc_cache_chk (.clk(clk), .rst(rst), .req_valid(req_valid),
    .req_write(req_write), .req_inhibit(req_inhibit), .req_wthru(req_wthru),
    .req_ready(req_ready), .resp_valid(resp_valid), .bus_req(bus_req), .bus_cmd(bus_cmd),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_ack(bus_ack));

// ### verification/dc_bus_mem.sv
// system bus memory model on the far side of the data cache
// assumes one clock; dly sets idle cycles before each ack
`timescale 1ns/1ns
module dc_bus_mem (
    input wire clk,
    input wire [1:0] dly,
    input wire bus_req,
    input wire [1:0] bus_cmd,
    input wire [31:0] bus_addr,
    input wire [31:0] bus_wdata,
    input wire [3:0] bus_be,
    output logic bus_ack,
    output logic [31:0] bus_rdata
);
    logic [31:0] mem [logic [29:0]];
    logic [31:0] last = 32'h0000_0000;
    logic [31:0] tmp;
    int wait_cnt = 0;
    function automatic logic [31:0] pat(input logic [31:0] a);
        return a ^ 32'hc3c3_0000;
    endfunction
    function automatic logic [31:0] peek(input logic [31:0] a);
        return mem.exists(a[31:2]) ? mem[a[31:2]] : pat({a[31:2], 2'h0});
    endfunction
    // ========================================
    // beat handshake; data lines show junk between beats so no stale word passes
    assign bus_ack = bus_req && (wait_cnt >= dly);
    assign bus_rdata = bus_ack ? peek(bus_addr) : ~last;
    always @(posedge clk) begin
        wait_cnt <= (bus_req && !bus_ack) ? wait_cnt + 1 : 0;
        if (bus_ack) begin
            last <= bus_rdata;
            if (bus_cmd[0]) begin
                tmp = peek(bus_addr);
                for (int k = 0; k < 4; k++) begin
                    if (bus_be[k]) tmp[8*k+:8] = bus_wdata[8*k+:8];
                end
                mem[bus_addr[31:2]] = tmp;
            end
        end
    end
endmodule // dc_bus_mem

// ### verification/test_two_way_data_cache.sv
// self-checking bench for the two-way data cache
// assumes dc_bus_mem on the bus side and the bound checker
`timescale 1ns/1ns
module test_two_way_data_cache;
    logic clk, rst, req_valid, req_write, req_inhibit, req_wthru, req_lock, req_unlock;
    logic [31:0] req_addr, req_wdata, rd, e;
    logic [3:0] req_be;
    logic [1:0] dly;
    wire req_ready, resp_valid, bus_req, bus_ack;
    wire [31:0] resp_rdata, bus_addr, bus_wdata, bus_rdata;
    wire [1:0] bus_cmd;
    wire [3:0] bus_be;
    int error_cnt = 0;
    int tests_run = 0;
    int lat;
    int n [4];
    dc_cache u_dc_cache (.clk(clk), .rst(rst), .req_valid(req_valid), .req_write(req_write),
        .req_addr(req_addr), .req_wdata(req_wdata), .req_be(req_be), .req_inhibit(req_inhibit),
        .req_wthru(req_wthru), .req_lock(req_lock), .req_unlock(req_unlock),
        .req_ready(req_ready), .resp_valid(resp_valid), .resp_rdata(resp_rdata),
        .bus_req(bus_req), .bus_cmd(bus_cmd), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_be(bus_be), .bus_ack(bus_ack), .bus_rdata(bus_rdata));
    dc_bus_mem u_dc_bus_mem (.clk(clk), .dly(dly), .bus_req(bus_req), .bus_cmd(bus_cmd),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_be(bus_be), .bus_ack(bus_ack),
        .bus_rdata(bus_rdata));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // beats per command: byte3 burst write, byte2 burst read, byte1 write, byte0 read
    always @(posedge clk) if (bus_req && bus_ack) n[bus_cmd]++;
    function automatic logic [31:0] cnts();
        return {n[3][7:0], n[2][7:0], n[1][7:0], n[0][7:0]};
    endfunction
    // ========================================
    // shared tasks
    task automatic give_verdict();
        if (error_cnt == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // md = {inhibit, write-through, lock, unlock}; entered and left at a falling edge
    task automatic acc(input logic w, input logic [31:0] a, input logic [31:0] d,
            input logic [3:0] be, input logic [3:0] md);
        n = '{0, 0, 0, 0};
        req_inhibit = md[3];
        req_wthru = md[2];
        req_lock = md[1];
        req_unlock = md[0];
        req_write = w;
        req_addr = a;
        req_wdata = d;
        req_be = be;
        req_valid = 1'b1;
        lat = 0;
        while (req_ready !== 1'b1 && lat < 50) begin
            @(negedge clk);
            lat++;
        end
        if (lat >= 50) begin
            error_cnt++;
            give_verdict();
        end
        @(negedge clk);
        req_valid = 1'b0;
        lat = 1;
        while (resp_valid !== 1'b1 && lat < 200) begin
            @(negedge clk);
            lat++;
        end
        if (lat >= 200) begin
            error_cnt++;
            give_verdict();
        end
        rd = resp_rdata;
        // let an edge pass so req_valid is never lowered and raised in one step
        @(negedge clk);
    endtask
    task automatic ld(input logic [31:0] a, input logic [3:0] md);
        acc(1'b0, a, 32'h0000_0000, 4'hf, md);
    endtask
    // ========================================
    // scenarios
    task automatic t_fill();
        dly = 2'h0;
        ld(32'h0000_1018, 4'h0);
        chk(rd, u_dc_bus_mem.pat(32'h0000_1018));
        chk(cnts(), 32'h0004_0000);
        ld(32'h0000_101c, 4'h0);
        chk(rd, u_dc_bus_mem.pat(32'h0000_101c));
        chk(lat, 1);
        chk(cnts(), 32'h0000_0000);
    endtask
    task automatic t_lru();
        ld(32'h0000_0020, 4'h0);
        ld(32'h0000_0820, 4'h0);
        ld(32'h0000_0020, 4'h0);
        chk(cnts(), 32'h0000_0000);
        ld(32'h0000_1020, 4'h0);
        ld(32'h0000_0020, 4'h0);
        chk(cnts(), 32'h0000_0000);
        ld(32'h0000_0820, 4'h0);
        chk(cnts(), 32'h0004_0000);
        chk(rd, u_dc_bus_mem.pat(32'h0000_0820));
    endtask
    task automatic t_lock();
        dly = 2'h1;
        ld(32'h0000_0030, 4'h2);
        ld(32'h0000_0830, 4'h2);
        ld(32'h0000_1030, 4'h0);
        chk(cnts(), 32'h0000_0001);
        chk(rd, u_dc_bus_mem.pat(32'h0000_1030));
        ld(32'h0000_1030, 4'h0);
        chk(cnts(), 32'h0000_0001);
        ld(32'h0000_0030, 4'h1);
        chk(cnts(), 32'h0000_0000);
        ld(32'h0000_1030, 4'h0);
        chk(cnts(), 32'h0004_0000);
        ld(32'h0000_0830, 4'h0);
        chk(cnts(), 32'h0000_0000);
    endtask
    task automatic t_inh();
        dly = 2'h3;
        ld(32'h0000_0040, 4'h8);
        ld(32'h0000_0040, 4'h8);
        chk(cnts(), 32'h0000_0001);
        chk(rd, u_dc_bus_mem.pat(32'h0000_0040));
        acc(1'b1, 32'h0000_0040, 32'h1234_5678, 4'hf, 4'h8);
        chk(cnts(), 32'h0000_0100);
        ld(32'h0000_0040, 4'h0);
        chk(cnts(), 32'h0004_0000);
        chk(rd, 32'h1234_5678);
    endtask
    task automatic t_cb();
        dly = 2'h1;
        ld(32'h0000_0050, 4'h0);
        acc(1'b1, 32'h0000_0050, 32'hcafe_0001, 4'hf, 4'h0);
        chk(cnts(), 32'h0000_0000);
        chk(lat, 1);
        ld(32'h0000_0050, 4'h0);
        chk(rd, 32'hcafe_0001);
        chk(u_dc_bus_mem.peek(32'h0000_0050), u_dc_bus_mem.pat(32'h0000_0050));
        ld(32'h0000_0850, 4'h0);
        ld(32'h0000_1050, 4'h0);
        chk(cnts(), 32'h0404_0000);
        chk(u_dc_bus_mem.peek(32'h0000_0050), 32'hcafe_0001);
        chk(u_dc_bus_mem.peek(32'h0000_0054), u_dc_bus_mem.pat(32'h0000_0054));
        chk(u_dc_bus_mem.peek(32'h0000_005c), u_dc_bus_mem.pat(32'h0000_005c));
    endtask
    task automatic t_wt();
        dly = 2'h0;
        ld(32'h0000_0060, 4'h0);
        acc(1'b1, 32'h0000_0060, 32'h0000_abcd, 4'h3, 4'h4);
        chk(cnts(), 32'h0000_0100);
        e = u_dc_bus_mem.pat(32'h0000_0060);
        e[15:0] = 16'habcd;
        chk(u_dc_bus_mem.peek(32'h0000_0060), e);
        ld(32'h0000_0060, 4'h0);
        chk(rd, e);
        chk(cnts(), 32'h0000_0000);
        // write-through store miss: fill, merge, then one single write
        acc(1'b1, 32'h0000_0070, 32'h5a5a_0000, 4'hc, 4'h4);
        chk(cnts(), 32'h0004_0100);
        e = u_dc_bus_mem.pat(32'h0000_0070);
        e[31:16] = 16'h5a5a;
        chk(u_dc_bus_mem.peek(32'h0000_0070), e);
        ld(32'h0000_0070, 4'h0);
        chk(rd, e);
    endtask
    initial begin
        req_valid = 1'b0;
        req_write = 1'b0;
        req_inhibit = 1'b0;
        req_wthru = 1'b0;
        req_lock = 1'b0;
        req_unlock = 1'b0;
        req_addr = 32'h0000_0000;
        req_wdata = 32'h0000_0000;
        req_be = 4'hf;
        dly = 2'h0;
        rst = 1'b1;
        repeat (10) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        t_fill();
        t_lru();
        t_lock();
        t_inh();
        t_cb();
        t_wt();
        give_verdict();
    end
endmodule // test_two_way_data_cache
